// ---- src/rlc_pkg.sv ----
// Constants, register indices and reset values of the clock configuration bank.
// Assumes a 100 MHz APB clock and byte-wide registers in the low data lanes.

package rlc_pkg;

	// ==========================================================
	// Bus geometry
	localparam int APB_AW = 12;
	localparam int REG_W = 8;

	// ==========================================================
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] IDX_STD_BASE_HI = 8'h60;
	localparam logic [7:0] IDX_STD_BASE_LO = 8'h61;
	localparam logic [7:0] IDX_EXT_BASE_HI = 8'h62;
	localparam logic [7:0] IDX_EXT_BASE_LO = 8'h63;
	localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
	localparam logic [7:0] IDX_IRQ_TYPE = 8'h71;
	localparam logic [7:0] IDX_DMA_A = 8'h74;
	localparam logic [7:0] IDX_DMA_B = 8'h75;
	localparam logic [7:0] IDX_LOCK_CTRL = 8'hE0;
	localparam logic [7:0] IDX_RAM_LOCK = 8'hF0;
	localparam logic [7:0] IDX_DAY_ALARM = 8'hF1;
	localparam logic [7:0] IDX_MONTH_ALARM = 8'hF2;
	localparam logic [7:0] IDX_CENTURY = 8'hF3;

	// ==========================================================
	// Reset values and write masks
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_STD_BASE_LO = 8'h70;
	localparam logic [7:0] RST_EXT_BASE_LO = 8'h72;
	localparam logic [7:0] RST_IRQ_NUM = 8'h08;
	localparam logic [7:0] DMA_NONE = 8'h04;
	localparam logic [7:0] BASE_LO_WMASK = 8'hFE;
	localparam logic [7:0] IRQ_TYPE_WMASK = 8'h02;
	localparam logic [7:0] OFFSET_WMASK = 8'h7F;
	localparam logic [7:0] LOCK_WMASK = 8'hF8;
	localparam int ACT_BIT = 0;

	// ==========================================================
	// Lock bit positions and lock control bits
	localparam int LOCK_STD_BLK = 7;
	localparam int LOCK_RAM_WR = 6;
	localparam int LOCK_EXT_WR_LOW = 5;
	localparam int LOCK_EXT_RD_LOW = 4;
	localparam int LOCK_EXT_ALL = 3;
	localparam int CTL_DOMAIN_BIT = 0;
	localparam int CTL_RELEASE_BIT = 1;

	// ==========================================================
	// Runtime map
	localparam logic [6:0] STD_FIRST_RAM = 7'h0E;
	localparam logic [6:0] STD_BLK_LO = 7'h38;
	localparam logic [6:0] STD_BLK_HI = 7'h3F;
	localparam logic [6:0] EXT_LOW_LAST = 7'h1F;
	localparam logic [6:0] IDX_SECONDS = 7'h00;
	localparam logic [7:0] EXT_RAM_START = 8'h72;
	localparam int RAM_BYTES = 242;
	localparam logic [7:0] BLOCKED_READ = 8'hFF;
	localparam logic [5:0] SECONDS_PER_MIN = 6'h3C;

	// ==========================================================
	// Timekeeping base
	localparam int RTC_BASE_HZ = 32768;

endpackage : rlc_pkg

// ---- src/rlc_lock_if.sv ----
// Carrier between the main bank and the standby-domain register bank.
// Assumes both ends run on the APB clock.

interface rlc_lock_if;
	import rlc_pkg::*;

	logic wr_en;
	logic [7:0] idx;
	logic [7:0] wdata;
	logic hit;
	logic [7:0] rdata;
	logic [7:0] lock_bits;

	modport bank (input wr_en, input idx, input wdata, output hit, output rdata, output lock_bits);
	modport host (output wr_en, output idx, output wdata, input hit, input rdata, input lock_bits);
endinterface : rlc_lock_if

// ---- src/rlc_sync.sv ----
// Two-stage synchroniser for levels arriving from outside the clock domain.
// Assumes the receiver tolerates two cycles of latency.

module rlc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;

	// ==========================================================
	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule // rlc_sync

// ---- src/rlc_lock_bank.sv ----
// Standby-domain registers: RAM lock, alarm and century offsets, lock control.
// Assumes standby_rst_n is the standby power-up reset and presetn the main one.

module rlc_lock_bank
	import rlc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic standby_rst_n,
	rlc_lock_if.bank bus
);
	logic main_rst_seen_reg;
	logic domain_sel_reg;
	logic [7:0] lock_reg;
	logic [7:0] day_reg;
	logic [7:0] month_reg;
	logic [7:0] century_reg;

	// ==========================================================
	// Flag that the main power reset is or was just asserted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) main_rst_seen_reg <= 1'b1;
		else main_rst_seen_reg <= 1'b0;
	end

	// ==========================================================
	// Lock domain select, standby domain
	// standby domain
	always_ff @(posedge pclk or negedge standby_rst_n) begin
		if (!standby_rst_n) domain_sel_reg <= 1'b0;
		else if (bus.wr_en && bus.idx == IDX_LOCK_CTRL) domain_sel_reg <= bus.wdata[CTL_DOMAIN_BIT];
	end

	// ==========================================================
	// RAM lock: write one to set, cleared only by reset or release
	always_ff @(posedge pclk or negedge standby_rst_n) begin
		if (!standby_rst_n) begin
			lock_reg <= RST_ZERO;
		end else if (main_rst_seen_reg && !domain_sel_reg) begin
			lock_reg <= RST_ZERO;
		end else if (bus.wr_en && bus.idx == IDX_LOCK_CTRL && bus.wdata[CTL_RELEASE_BIT]) begin
			lock_reg <= RST_ZERO;
		end else if (bus.wr_en && bus.idx == IDX_RAM_LOCK) begin
			lock_reg <= lock_reg | (bus.wdata & LOCK_WMASK);
		end
	end

	// ==========================================================
	// Offset registers, bit 7 reserved
	always_ff @(posedge pclk or negedge standby_rst_n) begin
		if (!standby_rst_n) begin
			day_reg <= RST_ZERO;
			month_reg <= RST_ZERO;
			century_reg <= RST_ZERO;
		end else if (bus.wr_en) begin
			if (bus.idx == IDX_DAY_ALARM) day_reg <= bus.wdata & OFFSET_WMASK;
			if (bus.idx == IDX_MONTH_ALARM) month_reg <= bus.wdata & OFFSET_WMASK;
			if (bus.idx == IDX_CENTURY) century_reg <= bus.wdata & OFFSET_WMASK;
		end
	end

	// ==========================================================
	// Read mux; release bit always reads zero
	always_comb begin
		bus.hit = 1'b1;
		bus.rdata = RST_ZERO;
		if (bus.idx == IDX_RAM_LOCK) bus.rdata = lock_reg;
		else if (bus.idx == IDX_DAY_ALARM) bus.rdata = day_reg;
		else if (bus.idx == IDX_MONTH_ALARM) bus.rdata = month_reg;
		else if (bus.idx == IDX_CENTURY) bus.rdata = century_reg;
		else if (bus.idx == IDX_LOCK_CTRL) bus.rdata = {7'h00, domain_sel_reg};
		else bus.hit = 1'b0;
	end

	assign bus.lock_bits = lock_reg;
endmodule // rlc_lock_bank

// ---- src/rlc_cfg.sv ----
// Clock logical device: APB configuration bank, runtime window and RAM.
// Assumes a 100 MHz pclk, a free 32.768 kHz pin and a same-clock runtime port.
//
// Implementation choice: the APB interface to the registers.

module rlc_cfg
	import rlc_pkg::*;
#(
	parameter int TICKS_PER_SEC = RTC_BASE_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic standby_rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic clk32k_in,
	input wire logic rt_req,
	input wire logic rt_write,
	input wire logic [15:0] rt_addr,
	input wire logic [7:0] rt_wdata,
	output logic rt_ack,
	output logic rt_hit,
	output logic [7:0] rt_rdata,
	output logic [7:0] irq_number_wake_enable,
	output logic [7:0] irq_type
);

	// ==========================================================
	// Declarations
	rlc_lock_if lock_bus ();
	logic [7:0] activate_reg;
	logic [7:0] std_hi_reg;
	logic [7:0] std_lo_reg;
	logic [7:0] ext_hi_reg;
	logic [7:0] ext_lo_reg;
	logic [7:0] irq_num_reg;
	logic [7:0] irq_type_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic setup;
	logic wr_fire;
	logic [7:0] reg_idx;
	logic aligned;
	logic [7:0] rd_value;
	logic rd_ok;
	logic clk32k_sync;
	logic clk32k_prev_reg;
	logic [15:0] prescale_reg;
	logic [5:0] seconds_reg;
	logic sec_tick;
	logic [6:0] std_ptr_reg;
	logic [6:0] ext_ptr_reg;
	logic [7:0] ram [0:RAM_BYTES-1];
	logic hit_std_idx;
	logic hit_std_dat;
	logic hit_ext_idx;
	logic hit_ext_dat;
	logic active;
	logic std_is_clock;
	logic std_rd_block;
	logic std_wr_block;
	logic ext_rd_block;
	logic ext_wr_block;
	logic [7:0] std_ram_addr;
	logic [7:0] ext_ram_addr;
	logic ram_we;
	logic [7:0] ram_waddr;
	logic rt_take;
	logic [7:0] rt_value;
	logic rt_claim;
	logic rt_ack_reg;
	logic rt_hit_reg;
	logic [7:0] rt_rdata_reg;

	// ==========================================================
	// Index match helper, used by read and write decode
	function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
		idx_is = (idx == want);
	endfunction

	// Pointer inside an inclusive range
	function automatic logic in_range(input logic [6:0] p, input logic [6:0] lo, input logic [6:0] hi);
		in_range = (p >= lo) && (p <= hi);
	endfunction

	// ==========================================================
	// APB phase decode
	assign setup = psel && !penable;
	assign wr_fire = psel && penable && pwrite && pstrb[0];
	assign reg_idx = paddr[9:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:10] == '0);
	assign lock_bus.wr_en = wr_fire && aligned;
	assign lock_bus.idx = reg_idx;
	assign lock_bus.wdata = pwdata[7:0];

	// ==========================================================
	// Activate register, main domain
	// main domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) activate_reg <= RST_ZERO;
		else if (wr_fire && aligned && idx_is(reg_idx, IDX_ACTIVATE)) activate_reg <= pwdata[7:0];
	end

	// ==========================================================
	// Window base registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_hi_reg <= RST_ZERO;
			std_lo_reg <= RST_STD_BASE_LO;
			ext_hi_reg <= RST_ZERO;
			ext_lo_reg <= RST_EXT_BASE_LO;
		end else if (wr_fire && aligned) begin
			if (idx_is(reg_idx, IDX_STD_BASE_HI)) std_hi_reg <= pwdata[7:0];
			if (idx_is(reg_idx, IDX_STD_BASE_LO)) std_lo_reg <= pwdata[7:0] & BASE_LO_WMASK;
			if (idx_is(reg_idx, IDX_EXT_BASE_HI)) ext_hi_reg <= pwdata[7:0];
			if (idx_is(reg_idx, IDX_EXT_BASE_LO)) ext_lo_reg <= pwdata[7:0] & BASE_LO_WMASK;
		end
	end

	// ==========================================================
	// Interrupt number and type registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_num_reg <= RST_IRQ_NUM;
			irq_type_reg <= RST_ZERO;
		end else if (wr_fire && aligned) begin
			if (idx_is(reg_idx, IDX_IRQ_NUM)) irq_num_reg <= pwdata[7:0];
			if (idx_is(reg_idx, IDX_IRQ_TYPE)) irq_type_reg <= pwdata[7:0] & IRQ_TYPE_WMASK;
		end
	end

	// ==========================================================
	// Read decode; unmapped or misaligned addresses give an error
	always_comb begin
		rd_value = RST_ZERO;
		rd_ok = aligned;
		if (!aligned) rd_ok = 1'b0;
		else if (idx_is(reg_idx, IDX_ACTIVATE)) rd_value = activate_reg;
		else if (idx_is(reg_idx, IDX_STD_BASE_HI)) rd_value = std_hi_reg;
		else if (idx_is(reg_idx, IDX_STD_BASE_LO)) rd_value = std_lo_reg;
		else if (idx_is(reg_idx, IDX_EXT_BASE_HI)) rd_value = ext_hi_reg;
		else if (idx_is(reg_idx, IDX_EXT_BASE_LO)) rd_value = ext_lo_reg;
		else if (idx_is(reg_idx, IDX_IRQ_NUM)) rd_value = irq_num_reg;
		else if (idx_is(reg_idx, IDX_IRQ_TYPE)) rd_value = irq_type_reg;
		else if (idx_is(reg_idx, IDX_DMA_A) || idx_is(reg_idx, IDX_DMA_B)) rd_value = DMA_NONE;
		else if (lock_bus.hit) rd_value = lock_bus.rdata;
		else rd_ok = 1'b0;
	end

	// ==========================================================
	// Read data and error are captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= pwrite ? '0 : {24'h000000, rd_value};
			pslverr_reg <= !rd_ok;
		end
	end

	// Zero wait states; writes to read-only locations are dropped
	// read-only ignore
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
	assign irq_number_wake_enable = irq_num_reg;
	assign irq_type = irq_type_reg;

	// ==========================================================
	// Standby bank and base clock synchroniser
	rlc_lock_bank u_lock_bank (
		.pclk(pclk),
		.presetn(presetn),
		.standby_rst_n(standby_rst_n),
		.bus(lock_bus.bank)
	);

	rlc_sync #(.W(1)) u_sync32k (
		.clk(pclk),
		.rst_n(presetn),
		.d(clk32k_in),
		.q(clk32k_sync)
	);

	// ==========================================================
	// Base clock edge detect and one-second prescaler
	// 32.768 kHz base
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk32k_prev_reg <= 1'b0;
			prescale_reg <= '0;
		end else begin
			clk32k_prev_reg <= clk32k_sync;
			if (clk32k_sync && !clk32k_prev_reg) begin
				if (prescale_reg == 16'(TICKS_PER_SEC - 1)) prescale_reg <= '0;
				else prescale_reg <= prescale_reg + 16'h0001;
			end
		end
	end

	assign sec_tick = clk32k_sync && !clk32k_prev_reg && (prescale_reg == 16'(TICKS_PER_SEC - 1));

	// ==========================================================
	// Runtime address decode
	always_comb begin
		active = activate_reg[ACT_BIT];
		hit_std_idx = (rt_addr == {std_hi_reg, std_lo_reg});
		hit_std_dat = (rt_addr == {std_hi_reg, std_lo_reg | 8'h01});
		hit_ext_idx = (rt_addr == {ext_hi_reg, ext_lo_reg});
		hit_ext_dat = (rt_addr == {ext_hi_reg, ext_lo_reg | 8'h01});
		std_is_clock = (std_ptr_reg < STD_FIRST_RAM);
		std_rd_block = lock_bus.lock_bits[LOCK_STD_BLK] && in_range(std_ptr_reg, STD_BLK_LO, STD_BLK_HI);
		std_wr_block = std_rd_block || lock_bus.lock_bits[LOCK_RAM_WR];
		ext_rd_block = lock_bus.lock_bits[LOCK_EXT_ALL]
			|| (lock_bus.lock_bits[LOCK_EXT_RD_LOW] && ext_ptr_reg <= EXT_LOW_LAST);
		ext_wr_block = lock_bus.lock_bits[LOCK_EXT_ALL] || lock_bus.lock_bits[LOCK_RAM_WR]
			|| (lock_bus.lock_bits[LOCK_EXT_WR_LOW] && ext_ptr_reg <= EXT_LOW_LAST);
		std_ram_addr = {1'b0, std_ptr_reg - STD_FIRST_RAM};
		ext_ram_addr = EXT_RAM_START + {1'b0, ext_ptr_reg};
	end

	assign rt_take = rt_req && active;
	assign rt_claim = rt_take && (hit_std_idx || hit_std_dat || hit_ext_idx || hit_ext_dat);

	// ==========================================================
	// RAM write port
	always_comb begin
		ram_we = 1'b0;
		ram_waddr = std_ram_addr;
		if (rt_take && rt_write && hit_std_dat && !std_is_clock && !std_wr_block) begin
			ram_we = 1'b1;
		end else if (rt_take && rt_write && hit_ext_dat && !ext_wr_block) begin
			ram_we = 1'b1;
			ram_waddr = ext_ram_addr;
		end
	end

	always_ff @(posedge pclk) begin
		if (ram_we) ram[ram_waddr] <= rt_wdata;
	end

	// ==========================================================
	// Runtime index pointers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			std_ptr_reg <= '0;
			ext_ptr_reg <= '0;
		end else if (rt_take && rt_write) begin
			if (hit_std_idx) std_ptr_reg <= rt_wdata[6:0];
			if (hit_ext_idx) ext_ptr_reg <= rt_wdata[6:0];
		end
	end

	// ==========================================================
	// Seconds counter, also written through the data port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seconds_reg <= '0;
		end else if (rt_take && rt_write && hit_std_dat && std_ptr_reg == IDX_SECONDS) begin
			seconds_reg <= (rt_wdata < {2'b00, SECONDS_PER_MIN}) ? rt_wdata[5:0] : '0;
		end else if (sec_tick) begin
			seconds_reg <= (seconds_reg == SECONDS_PER_MIN - 6'h01) ? '0 : seconds_reg + 6'h01;
		end
	end

	// ==========================================================
	// Runtime read value
	always_comb begin
		rt_value = BLOCKED_READ;
		if (hit_std_idx) rt_value = {1'b0, std_ptr_reg};
		else if (hit_ext_idx) rt_value = {1'b0, ext_ptr_reg};
		else if (hit_std_dat && std_ptr_reg == IDX_SECONDS) rt_value = {2'b00, seconds_reg};
		else if (hit_std_dat && std_is_clock) rt_value = RST_ZERO;
		else if (hit_std_dat && !std_rd_block) rt_value = ram[std_ram_addr];
		else if (hit_ext_dat && !ext_rd_block) rt_value = ram[ext_ram_addr];
	end

	// ==========================================================
	// Runtime answer, one cycle after the request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rt_ack_reg <= 1'b0;
			rt_hit_reg <= 1'b0;
			rt_rdata_reg <= BLOCKED_READ;
		end else begin
			rt_ack_reg <= rt_req;
			rt_hit_reg <= rt_claim;
			if (rt_req) rt_rdata_reg <= (rt_claim && !rt_write) ? rt_value : BLOCKED_READ;
		end
	end

	assign rt_ack = rt_ack_reg;
	assign rt_hit = rt_hit_reg;
	assign rt_rdata = rt_rdata_reg;

endmodule // rlc_cfg

// ---- tb/rlc_cfg_chk.sv ----
// Checker for the clock configuration bank, watching the top ports only.
// Assumes one pclk domain and presetn as its reset.
module rlc_cfg_chk
	import rlc_pkg::*;
#(
	parameter int TICKS_PER_SEC = RTC_BASE_HZ
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rt_req,
	input wire logic rt_ack,
	input wire logic rt_hit,
	input wire logic [7:0] irq_number_wake_enable,
	input wire logic [7:0] irq_type
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// Qualified bus phases
	logic wr_acc;
	logic rd_set;
	assign wr_acc = psel && penable && pwrite && pstrb[0];
	assign rd_set = psel && !penable && !pwrite;
	// ==========================================
	// Assertions
	AST_ZERO_WAIT: assert property (psel && penable |-> pready)
		else $error("pready low in access phase");
	AST_RT_ACK: assert property (rt_req |=> rt_ack)
		else $error("runtime ack not one cycle after request");
	AST_RT_NO_ACK: assert property (!rt_req |=> !rt_ack)
		else $error("runtime ack without request");
	AST_HIT_ACK: assert property (rt_hit |-> rt_ack)
		else $error("runtime hit outside ack");
	AST_IRQ_WR: assert property (wr_acc && paddr == {2'h0, IDX_IRQ_NUM, 2'h0} |=>
		irq_number_wake_enable == $past(pwdata[7:0])) else $error("irq number not written");
	AST_IRQ_HOLD: assert property (!(wr_acc && paddr == {2'h0, IDX_IRQ_NUM, 2'h0}) |=>
		$stable(irq_number_wake_enable)) else $error("irq number changed without write");
	AST_TYPE_RO: assert property ((irq_type & 8'hFD) == 8'h00)
		else $error("read-only interrupt type bits set");
	AST_TYPE_WR: assert property (wr_acc && paddr == {2'h0, IDX_IRQ_TYPE, 2'h0} |=>
		irq_type == ($past(pwdata[7:0]) & 8'h02)) else $error("interrupt type bit 1 not written");
	AST_DMA_RD: assert property (rd_set && paddr[11:3] == 9'h03A && paddr[1:0] == 2'h0 |=>
		prdata == 32'h00000004) else $error("no-DMA report wrong");
	AST_MISALIGN: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	// ==========================================
	// Scenario covers
	COV_LOCK_WR: cover property (wr_acc && paddr == {2'h0, IDX_RAM_LOCK, 2'h0});
	COV_HIT: cover property (rt_ack && rt_hit);
	COV_MISS: cover property (rt_ack && !rt_hit);
	COV_ERR: cover property (pslverr);
endmodule // rlc_cfg_chk

bind rlc_cfg rlc_cfg_chk #(.TICKS_PER_SEC(TICKS_PER_SEC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rt_req(rt_req), .rt_ack(rt_ack), .rt_hit(rt_hit),
	.irq_number_wake_enable(irq_number_wake_enable), .irq_type(irq_type));

// ---- tb/rlc_cfg_tb_top.sv ----
// Self-checking bench for the clock configuration bank.
// Assumes the checker is bound in; drives APB, runtime port and base clock pin.
module rlc_cfg_tb_top;
	import rlc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, standby_rst_n, psel, penable, pwrite, clk32k_in, rt_req, rt_write;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic pready, pslverr, rt_ack, rt_hit;
	logic [15:0] rt_addr;
	logic [7:0] rt_wdata, rt_rdata, irq_num, irq_typ;
	int failures = 0;
	int total_checks = 0;
	rlc_cfg #(.TICKS_PER_SEC(4)) uut (.pclk(pclk), .presetn(presetn), .standby_rst_n(standby_rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clk32k_in(clk32k_in), .rt_req(rt_req),
		.rt_write(rt_write), .rt_addr(rt_addr), .rt_wdata(rt_wdata), .rt_ack(rt_ack), .rt_hit(rt_hit),
		.rt_rdata(rt_rdata), .irq_number_wake_enable(irq_num), .irq_type(irq_typ));
	// ==========================================
	// Clocks: 100 MHz bus clock, base clock near 32.768 kHz
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		clk32k_in = 1'h0;
		forever begin
			repeat (1526) @(posedge pclk);
			clk32k_in <= ~clk32k_in;
		end
	end
	// ==========================================
	// Verdict and comparison
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", s, exp, seen);
		end
	endtask
	// ==========================================
	// APB master, one transfer
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] q,
		output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (n == 16) begin
			failures++;
			complete_run();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'h1, {2'h0, i, 2'h0}, d, q, e);
	endtask
	task automatic rdc(input string s, input logic [7:0] i, input logic [7:0] x);
		logic [31:0] q;
		logic e;
		apb(1'h0, {2'h0, i, 2'h0}, 8'h00, q, e);
		chk(s, q, {24'h000000, x});
	endtask
	// ==========================================
	// Runtime port: one request, then index/data pair into the standard window
	task automatic rt(input logic w, input logic [15:0] a, input logic [7:0] d, output logic h,
		output logic [7:0] q);
		@(posedge pclk);
		rt_req <= 1'h1;
		rt_write <= w;
		rt_addr <= a;
		rt_wdata <= d;
		@(posedge pclk);
		rt_req <= 1'h0;
		// Answer registered at the request edge, taken at the next edge
		@(posedge pclk);
		h = rt_hit;
		q = rt_rdata;
		chk("rt_ack", {31'h0, rt_ack}, 32'h1);
	endtask
	task automatic ram(input logic w, input logic [7:0] i, input logic [7:0] d, output logic h,
		output logic [7:0] q);
		rt(1'h1, 16'h0070, i, h, q);
		rt(w, 16'h0071, d, h, q);
	endtask
	task automatic pulse(input logic main);
		@(posedge pclk);
		if (main)
			presetn <= 1'h0;
		else
			standby_rst_n <= 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		standby_rst_n <= 1'h1;
		@(posedge pclk);
	endtask
	// Bounded wait for k fresh rising edges of the base clock pin
	task automatic wait32(input int k);
		int n;
		repeat (k) begin
			n = 0;
			while (clk32k_in !== 1'h0 && n < 8000) begin
				@(posedge pclk);
				n++;
			end
			while (clk32k_in !== 1'h1 && n < 8000) begin
				@(posedge pclk);
				n++;
			end
			if (n >= 8000) begin
				failures++;
				complete_run();
			end
		end
	endtask
	// ==========================================
	// Scenarios
	logic [7:0] idx [13] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0, 8'hF1,
		8'hF2, 8'hF3};
	logic [7:0] rst [13] = '{8'h00, 8'h00, 8'h70, 8'h00, 8'h72, 8'h08, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00,
		8'h00, 8'h00};
	logic [7:0] ones [13] = '{8'hFF, 8'hFF, 8'hFE, 8'hFF, 8'hFE, 8'hFF, 8'h02, 8'h04, 8'h04, 8'hF8, 8'h7F,
		8'h7F, 8'h7F};
	logic [7:0] zero [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'hF8, 8'h00,
		8'h00, 8'h00};
	task automatic t_regs();
		foreach (idx[k]) rdc("reset value", idx[k], rst[k]);
		foreach (idx[k]) wr(idx[k], 8'hFF);
		foreach (idx[k]) rdc("after ones", idx[k], ones[k]);
		foreach (idx[k]) wr(idx[k], 8'h00);
		foreach (idx[k]) rdc("after zeros", idx[k], zero[k]);
		wr(IDX_LOCK_CTRL, 8'h02);
		rdc("lock released", IDX_RAM_LOCK, 8'h00);
		wr(IDX_STD_BASE_LO, 8'h70);
	endtask
	task automatic t_unmapped();
		logic [31:0] q;
		logic e;
		apb(1'h0, 12'h100, 8'h00, q, e);
		chk("unmapped err", {31'h0, e}, 32'h1);
		apb(1'h1, 12'h1C5, 8'hFF, q, e);
		chk("misaligned err", {31'h0, e}, 32'h1);
		pstrb <= 4'hE;
		apb(1'h1, {2'h0, IDX_IRQ_TYPE, 2'h0}, 8'hFF, q, e);
		pstrb <= 4'hF;
		chk("masked write err", {31'h0, e}, 32'h0);
		rdc("irq type kept", IDX_IRQ_TYPE, 8'h00);
	endtask
	task automatic t_runtime();
		logic h;
		logic [7:0] q;
		ram(1'h0, 8'h38, 8'h00, h, q);
		chk("inactive hit", {31'h0, h}, 32'h0);
		chk("inactive data", {24'h0, q}, 32'hFF);
		wr(IDX_ACTIVATE, 8'h01);
		ram(1'h1, 8'h38, 8'h5A, h, q);
		ram(1'h0, 8'h38, 8'h00, h, q);
		chk("ram data", {23'h0, h, q}, 32'h15A);
		wr(IDX_RAM_LOCK, 8'h80);
		ram(1'h1, 8'h38, 8'hA5, h, q);
		ram(1'h0, 8'h38, 8'h00, h, q);
		chk("locked read", {24'h0, q}, 32'hFF);
		wr(IDX_LOCK_CTRL, 8'h02);
		rdc("release reads zero", IDX_LOCK_CTRL, 8'h00);
		ram(1'h0, 8'h38, 8'h00, h, q);
		chk("write ignored", {24'h0, q}, 32'h5A);
	endtask
	task automatic t_seconds();
		logic h;
		logic [7:0] s0, s1;
		wait32(1);
		repeat (5) @(posedge pclk);
		ram(1'h0, 8'h00, 8'h00, h, s0);
		chk("seconds range", {31'h0, s0 < 8'h3C}, 32'h1);
		wait32(8);
		repeat (5) @(posedge pclk);
		ram(1'h0, 8'h00, 8'h00, h, s1);
		chk("seconds step", {24'h0, s1}, {24'h0, s0 + 8'h02});
	endtask
	task automatic t_domains();
		wr(IDX_DAY_ALARM, 8'h55);
		wr(IDX_IRQ_NUM, 8'h33);
		wr(IDX_RAM_LOCK, 8'h40);
		pulse(1'h1);
		rdc("standby kept", IDX_DAY_ALARM, 8'h55);
		rdc("main reset", IDX_IRQ_NUM, 8'h08);
		chk("irq port", {24'h0, irq_num}, 32'h08);
		rdc("lock main clr", IDX_RAM_LOCK, 8'h00);
		wr(IDX_LOCK_CTRL, 8'h01);
		wr(IDX_RAM_LOCK, 8'h40);
		pulse(1'h1);
		rdc("lock survives", IDX_RAM_LOCK, 8'h40);
		pulse(1'h0);
		rdc("lock standby", IDX_RAM_LOCK, 8'h00);
		rdc("offset standby", IDX_DAY_ALARM, 8'h00);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		{psel, penable, pwrite, rt_req, rt_write} = 5'h00;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		pstrb = 4'hF;
		rt_addr = 16'h0000;
		rt_wdata = 8'h00;
		presetn = 1'h0;
		standby_rst_n = 1'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		standby_rst_n <= 1'h1;
		t_regs();
		t_unmapped();
		t_runtime();
		t_seconds();
		t_domains();
		complete_run();
	end
endmodule // rlc_cfg_tb_top
